// ### rtl/skip_xfer_pkg.sv
// constants for the skip and transfer execution unit
// assumes a 10-bit instruction word and 4-bit data path
package skip_xfer_pkg;
  localparam int                OPW         = 10;
  localparam int                NIB         = 4;
  // opcodes
  localparam logic [OPW-1:0]    OP_SKT1     = 10'h280;
  localparam logic [OPW-1:0]    OP_SKT2     = 10'h281;
  localparam logic [OPW-1:0]    OP_SKMB     = 10'h020; // low 2 bits = j
  localparam logic [OPW-1:0]    OP_SKMB_MSK = 10'h3fc;
  localparam logic [OPW-1:0]    OP_SKC      = 10'h02f;
  localparam logic [OPW-1:0]    OP_SKPD     = 10'h02b;
  localparam logic [OPW-1:0]    OP_WRT1     = 10'h230;
  localparam logic [OPW-1:0]    OP_WRT2     = 10'h231;
  localparam logic [OPW-1:0]    OP_CPYBA    = 10'h01e;
  localparam logic [OPW-1:0]    OP_RDT1     = 10'h270;
  localparam logic [OPW-1:0]    OP_RDT2     = 10'h271;
  localparam logic [OPW-1:0]    OP_RDAD     = 10'h279;
  // bit positions
  localparam int                T1_DIS_BIT  = 2;
  localparam int                T2_DIS_BIT  = 3;
  localparam int                MODE_BIT    = 3;
  localparam logic [2:0]        PORT_MAX    = 3'h5;
  localparam int                PORT_BITS   = 6;
  // interrupt status bits
  localparam int                EV_SKIP     = 0;
  localparam int                EV_T1CLR    = 1;
  localparam int                EV_T2CLR    = 2;
  localparam int                EV_BADY     = 3;
  // wishbone word byte offsets
  localparam logic [3:0]        ADR_STAT    = 4'h0;
  localparam logic [3:0]        ADR_MASK    = 4'h4;
  localparam logic [3:0]        ADR_CTRL    = 4'h8;
  localparam logic [3:0]        ADR_STATE   = 4'hc;
  localparam logic [NIB-1:0]    RST_NIB     = 4'h0;
  typedef enum logic [1:0] {EX_IDLE, EX_SECOND, EX_SUPPR} ex_state_t;
endpackage

// ### rtl/skip_xfer_exec.sv
// execution of flag/bit skips and timer, converter transfers
// assumes the fetch core presents one word per cycle with a valid strobe
// Summary of operation
// RULE1: timer1 flag skip and clear, unless disabled
// RULE2: timer2 flag skip and clear, unless disabled
// RULE3: skip when memory bit j is zero
// RULE4: skip when carry zero, carry kept
// RULE5: two-cycle skip when port bit Y zero
// RULE6: aux/acc load timer1 and its reload
// RULE7: aux/acc load timer2 and its reload
// RULE8: copy aux into accumulator, no flags
// RULE9: timer1 halves into aux and accumulator
// RULE10: timer2 halves into aux and accumulator
// RULE11: converter mode: result bits 9..2 read
// RULE12: comparator mode: comparator bits read
// RULE13: skipped instruction is fetched but suppressed
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module skip_xfer_exec #(
  parameter int NIB = 4
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  // instruction stream from fetch core
  input  wire logic [9:0]      instrWord,
  input  wire logic            instrValid,
  output logic                 instrBusy,
  output logic                 skipNext,
  // core state read by the unit
  input  wire logic [NIB-1:0]  memWord,
  input  wire logic            carryFlag,
  input  wire logic [2:0]      indexY,
  input  wire logic [5:0]      portBits,
  input  wire logic [NIB-1:0]  intCtrlOne,
  input  wire logic [NIB-1:0]  converterControl,
  input  wire logic [9:0]      converterResult,
  input  wire logic [7:0]      comparatorReg,
  // timer request flags from timer block
  input  wire logic            timerOneRequestFlag,
  input  wire logic            timerTwoRequestFlag,
  output logic                 timerOneFlagClear,
  output logic                 timerTwoFlagClear,
  // timer read values
  input  wire logic [7:0]      timerOneValue,
  input  wire logic [7:0]      timerTwoValue,
  // timer and reload load, one-cycle strobes
  output logic                 timerOneLoad,
  output logic                 timerTwoLoad,
  output logic [7:0]           timerLoadData,
  // accumulator and aux registers
  output logic [NIB-1:0]       accOut,
  output logic [NIB-1:0]       auxOut,
  input  wire logic            accLoadIn,
  input  wire logic [NIB-1:0]  accDataIn,
  input  wire logic            auxLoadIn,
  input  wire logic [NIB-1:0]  auxDataIn,
  // wishbone classic slave
  input  wire logic            cyc_i,
  input  wire logic            stb_i,
  input  wire logic            we_i,
  input  wire logic [3:0]      adr_i,
  input  wire logic [3:0]      sel_i,
  input  wire logic [31:0]     dat_i,
  output logic [31:0]          dat_o,
  output logic                 ack_o,
  output logic                 irq
);
  // pin-side port bits pass a two-stage synchroniser
  logic [5:0] portS1_ff, portS2_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      portS1_ff <= '0;
      portS2_ff <= '0;
    end else begin
      portS1_ff <= portBits;
      portS2_ff <= portS1_ff;
    end
  end

  skip_xfer_pkg::ex_state_t state_ff, nxt_state;
  logic [NIB-1:0] acc_ff, nxt_acc, aux_ff, nxt_aux;
  logic           skip_ff, nxt_skip;
  logic           t1c_ff, nxt_t1c, t2c_ff, nxt_t2c;
  logic           t1l_ff, nxt_t1l, t2l_ff, nxt_t2l;
  logic [7:0]     ld_ff, nxt_ld;
  logic [3:0]     stat_ff, nxt_stat, mask_ff, nxt_mask;
  logic           hold_ff, nxt_hold;
  logic           ack_ff, nxt_ack;
  logic [31:0]    dat_ff, nxt_dat;
  logic [3:0]     ev;
  logic           exec;
  logic [1:0]     bitJ;

  assign exec = instrValid && (state_ff == skip_xfer_pkg::EX_IDLE);
  assign bitJ = instrWord[1:0];

  // decode and execute; a suppressed word changes nothing
  always_comb begin
    nxt_state = state_ff;
    nxt_acc   = accLoadIn ? accDataIn : acc_ff;
    nxt_aux   = auxLoadIn ? auxDataIn : aux_ff;
    nxt_skip  = 1'b0;
    nxt_t1c   = 1'b0;
    nxt_t2c   = 1'b0;
    nxt_t1l   = 1'b0;
    nxt_t2l   = 1'b0;
    nxt_ld    = ld_ff;
    ev        = '0;
    case (state_ff)
      skip_xfer_pkg::EX_SUPPR: begin
        // fetched word dropped without effect
        if (instrValid) nxt_state = skip_xfer_pkg::EX_IDLE; // RULE13
      end
      skip_xfer_pkg::EX_SECOND: begin
        // second word of the port test is consumed here
        if (instrValid) begin
          nxt_state = skip_xfer_pkg::EX_IDLE;
          if (indexY > skip_xfer_pkg::PORT_MAX) begin
            ev[skip_xfer_pkg::EV_BADY] = 1'b1; // out of range: no skip
          end else if (!portS2_ff[indexY]) begin
            nxt_skip = 1'b1; // RULE5
          end
        end
      end
      default: begin
        if (exec) begin
          if (instrWord == skip_xfer_pkg::OP_SKT1) begin
            if (!intCtrlOne[skip_xfer_pkg::T1_DIS_BIT] &&
                timerOneRequestFlag) begin
              nxt_skip = 1'b1; // RULE1
              nxt_t1c  = 1'b1; // RULE1
              ev[skip_xfer_pkg::EV_T1CLR] = 1'b1;
            end
          end else if (instrWord == skip_xfer_pkg::OP_SKT2) begin
            if (!intCtrlOne[skip_xfer_pkg::T2_DIS_BIT] &&
                timerTwoRequestFlag) begin
              nxt_skip = 1'b1; // RULE2
              nxt_t2c  = 1'b1; // RULE2
              ev[skip_xfer_pkg::EV_T2CLR] = 1'b1;
            end
          end else if ((instrWord & skip_xfer_pkg::OP_SKMB_MSK) ==
                       skip_xfer_pkg::OP_SKMB) begin
            nxt_skip = !memWord[bitJ]; // RULE3
          end else if (instrWord == skip_xfer_pkg::OP_SKC) begin
            nxt_skip = !carryFlag; // RULE4
          end else if (instrWord == skip_xfer_pkg::OP_SKPD) begin
            nxt_state = skip_xfer_pkg::EX_SECOND; // RULE5
          end else if (instrWord == skip_xfer_pkg::OP_WRT1) begin
            nxt_ld  = {aux_ff, acc_ff}; // RULE6
            nxt_t1l = 1'b1;
          end else if (instrWord == skip_xfer_pkg::OP_WRT2) begin
            nxt_ld  = {aux_ff, acc_ff}; // RULE7
            nxt_t2l = 1'b1;
          end else if (instrWord == skip_xfer_pkg::OP_CPYBA) begin
            nxt_acc = aux_ff; // RULE8
          end else if (instrWord == skip_xfer_pkg::OP_RDT1) begin
            {nxt_aux, nxt_acc} = timerOneValue; // RULE9
          end else if (instrWord == skip_xfer_pkg::OP_RDT2) begin
            {nxt_aux, nxt_acc} = timerTwoValue; // RULE10
          end else if (instrWord == skip_xfer_pkg::OP_RDAD) begin
            if (converterControl[skip_xfer_pkg::MODE_BIT]) begin
              {nxt_aux, nxt_acc} = comparatorReg; // RULE12
            end else begin
              {nxt_aux, nxt_acc} = converterResult[9:2]; // RULE11
            end
          end
        end
      end
    endcase
    if (nxt_skip) begin
      nxt_state = skip_xfer_pkg::EX_SUPPR; // RULE13
      ev[skip_xfer_pkg::EV_SKIP] = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= skip_xfer_pkg::EX_IDLE;
      acc_ff   <= skip_xfer_pkg::RST_NIB;
      aux_ff   <= skip_xfer_pkg::RST_NIB;
      skip_ff  <= 1'b0;
      t1c_ff   <= 1'b0;
      t2c_ff   <= 1'b0;
      t1l_ff   <= 1'b0;
      t2l_ff   <= 1'b0;
      ld_ff    <= '0;
    end else begin
      state_ff <= nxt_state;
      acc_ff   <= nxt_acc;
      aux_ff   <= nxt_aux;
      skip_ff  <= nxt_skip;
      t1c_ff   <= nxt_t1c;
      t2c_ff   <= nxt_t2c;
      t1l_ff   <= nxt_t1l;
      t2l_ff   <= nxt_t2l;
      ld_ff    <= nxt_ld;
    end
  end

  // bus slave: ack one cycle after request; read clears status
  logic        req;
  logic [31:0] stRead;
  assign req    = cyc_i && stb_i && !ack_ff;
  assign stRead = {28'h0, stat_ff};
  always_comb begin
    nxt_ack  = req;
    nxt_dat  = dat_ff;
    nxt_mask = mask_ff;
    nxt_hold = hold_ff;
    nxt_stat = stat_ff;
    if (req && !we_i) begin
      case (adr_i)
        skip_xfer_pkg::ADR_STAT: begin
          nxt_dat  = stRead;
          nxt_stat = '0;
        end
        skip_xfer_pkg::ADR_MASK:  nxt_dat = {28'h0, mask_ff};
        skip_xfer_pkg::ADR_CTRL:  nxt_dat = {31'h0, hold_ff};
        skip_xfer_pkg::ADR_STATE: nxt_dat = {22'h0, aux_ff, acc_ff,
                                             state_ff};
        default:                  nxt_dat = '0;
      endcase
    end
    if (req && we_i && sel_i[0]) begin
      if (adr_i == skip_xfer_pkg::ADR_MASK) nxt_mask = dat_i[3:0];
      if (adr_i == skip_xfer_pkg::ADR_CTRL) nxt_hold = dat_i[0];
    end
    // set wins over the clearing read
    nxt_stat = nxt_stat | ev;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff  <= 1'b0;
      dat_ff  <= '0;
      mask_ff <= '0;
      hold_ff <= 1'b0;
      stat_ff <= '0;
    end else begin
      ack_ff  <= nxt_ack;
      dat_ff  <= nxt_dat;
      mask_ff <= nxt_mask;
      hold_ff <= nxt_hold;
      stat_ff <= nxt_stat;
    end
  end

  // software hold stalls the fetch core; the second-word wait does not
  assign instrBusy         = hold_ff;
  assign skipNext          = skip_ff;
  assign timerOneFlagClear = t1c_ff;
  assign timerTwoFlagClear = t2c_ff;
  assign timerOneLoad      = t1l_ff;
  assign timerTwoLoad      = t2l_ff;
  assign timerLoadData     = ld_ff;
  assign accOut            = acc_ff;
  assign auxOut            = aux_ff;
  assign dat_o             = dat_ff;
  assign ack_o             = ack_ff;
  assign irq               = |(stat_ff & mask_ff);

  // checks
  t1_skip_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
    (exec && instrWord == skip_xfer_pkg::OP_SKT1 &&
     !intCtrlOne[skip_xfer_pkg::T1_DIS_BIT] && timerOneRequestFlag)
    |=> timerOneFlagClear && skipNext)
    else $error("timer1 skip missing");
  t1_nop_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
    (exec && instrWord == skip_xfer_pkg::OP_SKT1 &&
     intCtrlOne[skip_xfer_pkg::T1_DIS_BIT]) |=> !timerOneFlagClear)
    else $error("timer1 test not a nop");
  t2_skip_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
    (exec && instrWord == skip_xfer_pkg::OP_SKT2 &&
     !intCtrlOne[skip_xfer_pkg::T2_DIS_BIT] && timerTwoRequestFlag)
    |=> timerTwoFlagClear && skipNext)
    else $error("timer2 skip missing");
  carry_skip_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
    (exec && instrWord == skip_xfer_pkg::OP_SKC) |=>
    skipNext == !$past(carryFlag))
    else $error("carry skip wrong");
  port_two_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
    (exec && instrWord == skip_xfer_pkg::OP_SKPD) |=>
    state_ff == skip_xfer_pkg::EX_SECOND && !skipNext)
    else $error("port test not two words");
  wr_t1_a: assert property (@(posedge mclk) disable iff (rst) // RULE6
    (exec && instrWord == skip_xfer_pkg::OP_WRT1) |=>
    timerOneLoad && timerLoadData == {$past(aux_ff), $past(acc_ff)})
    else $error("timer1 load wrong");
  rd_t2_a: assert property (@(posedge mclk) disable iff (rst) // RULE10
    (exec && instrWord == skip_xfer_pkg::OP_RDT2 && !accLoadIn && !auxLoadIn)
    |=> {auxOut, accOut} == $past(timerTwoValue))
    else $error("timer2 read wrong");
  suppr_a: assert property (@(posedge mclk) disable iff (rst) // RULE13
    (state_ff == skip_xfer_pkg::EX_SUPPR && !accLoadIn && !auxLoadIn)
    |=> $stable(accOut) && !timerOneLoad && !timerTwoLoad)
    else $error("skipped word had effect");
  t2_nop_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
    (exec && instrWord == skip_xfer_pkg::OP_SKT2 &&
     intCtrlOne[skip_xfer_pkg::T2_DIS_BIT]) |=> !timerTwoFlagClear)
    else $error("timer2 test not a nop");
  mem_skip_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
    (exec && (instrWord & skip_xfer_pkg::OP_SKMB_MSK) ==
     skip_xfer_pkg::OP_SKMB && !memWord[bitJ]) |=> skipNext)
    else $error("memory bit skip missing");
  mem_run_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
    (exec && (instrWord & skip_xfer_pkg::OP_SKMB_MSK) ==
     skip_xfer_pkg::OP_SKMB && memWord[bitJ]) |=> !skipNext)
    else $error("memory bit skip spurious");
  port_skip_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
    (state_ff == skip_xfer_pkg::EX_SECOND && instrValid &&
     indexY <= skip_xfer_pkg::PORT_MAX && !portS2_ff[indexY]) |=> skipNext)
    else $error("port bit skip missing");
  port_run_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
    (state_ff == skip_xfer_pkg::EX_SECOND && instrValid &&
     (indexY > skip_xfer_pkg::PORT_MAX || portS2_ff[indexY])) |=> !skipNext)
    else $error("port bit skip spurious");
  wr_t2_a: assert property (@(posedge mclk) disable iff (rst) // RULE7
    (exec && instrWord == skip_xfer_pkg::OP_WRT2) |=>
    timerTwoLoad && timerLoadData == {$past(aux_ff), $past(acc_ff)})
    else $error("timer2 load wrong");
  copy_acc_a: assert property (@(posedge mclk) disable iff (rst) // RULE8
    (exec && instrWord == skip_xfer_pkg::OP_CPYBA) |=>
    accOut == $past(aux_ff) && !skipNext)
    else $error("copy into accumulator wrong");
  rd_t1_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
    (exec && instrWord == skip_xfer_pkg::OP_RDT1) |=>
    {auxOut, accOut} == $past(timerOneValue))
    else $error("timer1 read wrong");
  rd_conv_a: assert property (@(posedge mclk) disable iff (rst) // RULE11
    (exec && instrWord == skip_xfer_pkg::OP_RDAD &&
     !converterControl[skip_xfer_pkg::MODE_BIT]) |=>
    {2'h0, auxOut, accOut} == ($past(converterResult) >> 2))
    else $error("converter result read wrong");
  rd_cmp_a: assert property (@(posedge mclk) disable iff (rst) // RULE12
    (exec && instrWord == skip_xfer_pkg::OP_RDAD &&
     converterControl[skip_xfer_pkg::MODE_BIT]) |=>
    {auxOut, accOut} == $past(comparatorReg))
    else $error("comparator read wrong");
  suppr_flag_a: assert property (@(posedge mclk) disable iff (rst) // RULE13
    (state_ff == skip_xfer_pkg::EX_SUPPR) |=>
    !skipNext && !timerOneFlagClear && !timerTwoFlagClear)
    else $error("skipped word raised a flag action");
endmodule // skip_xfer_exec
`default_nettype wire

// ### sim/timer_side_model.sv
// stand-in for the timer block beside the execution unit
// assumes the unit's mclk and rst; timers hold their load, never count
`timescale 1ns/1ns
`default_nettype none
module timer_side_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // requests from bench, strobes from unit
  input  wire logic [1:0] setReq,
  input  wire logic [1:0] clearStrobe,
  input  wire logic [1:0] loadStrobe,
  input  wire logic [7:0] loadData,
  // state seen by the unit
  output logic [1:0]      reqFlag,
  output logic [7:0]      valOne,
  output logic [7:0]      valTwo
);
  // set beats clear so a fresh request is never lost
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reqFlag <= 2'h0;
      valOne <= 8'h00;
      valTwo <= 8'h00;
    end else begin
      reqFlag <= setReq | (reqFlag & ~clearStrobe);
      if (loadStrobe[0]) valOne <= loadData;
      if (loadStrobe[1]) valTwo <= loadData;
    end
  end
endmodule // timer_side_model
`default_nettype wire

// ### sim/test_skip_xfer_exec.sv
// self-checking bench for the skip and transfer unit
// assumes the design sources and the timer stand-in are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_skip_xfer_exec;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  instrWord = 10'h000;
  logic        instrValid = 1'b0;
  logic [3:0]  memWord = 4'h5;
  logic        carryFlag = 1'b0;
  logic [2:0]  indexY = 3'h0;
  logic [5:0]  portBits = 6'h2a;
  logic [3:0]  intCtrlOne = 4'h0;
  logic [3:0]  converterControl = 4'h0;
  logic [9:0]  converterResult = 10'h2b6;
  logic [7:0]  comparatorReg = 8'h47;
  logic        accLoadIn = 1'b0;
  logic        auxLoadIn = 1'b0;
  logic [3:0]  accDataIn = 4'h0;
  logic [3:0]  auxDataIn = 4'h0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [1:0]  setReq = 2'h0;
  logic [31:0] rd;
  logic [7:0]  tv [2] = '{8'ha5, 8'h3c};
  int          errTotal = 0;
  int          samplesChecked = 0;
  int          cycles = 0;
  wire logic        instrBusy, skipNext, ack_o, irq;
  wire logic [1:0]  clearStrobe, loadStrobe, reqFlag;
  wire logic [7:0]  timerLoadData, valOne, valTwo;
  wire logic [3:0]  accOut, auxOut;
  wire logic [31:0] dat_o;

  skip_xfer_exec u_skip_xfer_exec (.mclk, .rst, .instrWord, .instrValid,
    .instrBusy, .skipNext, .memWord, .carryFlag, .indexY, .portBits,
    .intCtrlOne, .converterControl, .converterResult, .comparatorReg,
    .timerOneRequestFlag(reqFlag[0]), .timerTwoRequestFlag(reqFlag[1]),
    .timerOneFlagClear(clearStrobe[0]), .timerTwoFlagClear(clearStrobe[1]),
    .timerOneValue(valOne), .timerTwoValue(valTwo),
    .timerOneLoad(loadStrobe[0]), .timerTwoLoad(loadStrobe[1]),
    .timerLoadData, .accOut, .auxOut, .accLoadIn, .accDataIn, .auxLoadIn,
    .auxDataIn, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .irq);
  timer_side_model u_timer_side_model (.mclk, .rst, .setReq, .clearStrobe,
    .loadStrobe, .loadData(timerLoadData), .reqFlag, .valOne, .valTwo);

  // 20 MHz clock
  always #25 mclk = ~mclk;

  task finishTest;
    if (errTotal == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the roughly 170 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      finishTest();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e) begin
      errTotal++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one word; returns mid-cycle after the taking edge, so the one-cycle
  // strobes are looked at while they stand, not at the edge ending them
  task step(input logic [9:0] w);
    @(posedge mclk);
    instrWord <= w;
    instrValid <= 1'b1;
    @(posedge mclk);
    instrValid <= 1'b0;
    @(negedge mclk);
  endtask

  task setab(input logic [3:0] b, input logic [3:0] a);
    @(posedge mclk);
    {auxLoadIn, auxDataIn, accLoadIn, accDataIn} <= {1'b1, b, 1'b1, a};
    @(posedge mclk);
    {auxLoadIn, accLoadIn} <= 2'h0;
  endtask

  task raise(input int t);
    @(posedge mclk);
    setReq[t] <= 1'b1;
    @(posedge mclk);
    setReq <= 2'h0;
  endtask

  // classic cycle held until ack, then one idle cycle
  // no local limit: only the hang guard ends a wait for ack
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hf};
    do begin
      @(posedge mclk);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
    @(posedge mclk);
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // flag skips, enabled and disabled; filler word absorbs any skip
    for (int t = 0; t < 2; t++) begin
      for (int d = 0; d < 2; d++) begin
        raise(t);
        intCtrlOne <= d ? (4'h4 << t) : 4'h0;
        step(skip_xfer_pkg::OP_SKT1 | 10'(t));
        chk(skipNext, !d);
        chk(clearStrobe[t], !d);
        step(10'h000);
        chk(reqFlag[t], d);
      end
    end
    for (int j = 0; j < 4; j++) begin
      step(skip_xfer_pkg::OP_SKMB | 10'(j));
      chk(skipNext, !memWord[j]);
      step(10'h000);
    end
    for (int c = 0; c < 2; c++) begin
      @(posedge mclk);
      carryFlag <= c[0];
      step(skip_xfer_pkg::OP_SKC);
      chk(skipNext, !c);
      step(10'h000);
    end
    // index 6 is out of range: never a skip
    for (int y = 0; y < 7; y++) begin
      @(posedge mclk);
      indexY <= 3'(y);
      step(skip_xfer_pkg::OP_SKPD);
      step(10'h000);
      chk(skipNext, y < 6 && !portBits[y]);
      step(10'h000);
    end
    for (int t = 0; t < 2; t++) begin
      setab(tv[t][7:4], tv[t][3:0]);
      step(skip_xfer_pkg::OP_WRT1 | 10'(t));
      chk(loadStrobe, 2'h1 << t);
      chk(timerLoadData, tv[t]);
    end
    for (int t = 0; t < 2; t++) begin
      setab(4'h0, 4'h0);
      step(skip_xfer_pkg::OP_RDT1 | 10'(t));
      chk({auxOut, accOut}, tv[t]);
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      converterControl <= m ? 4'h8 : 4'h0;
      step(skip_xfer_pkg::OP_RDAD);
      chk({auxOut, accOut}, m ? 8'h47 : 8'had);
    end
    setab(4'h9, 4'h2);
    step(skip_xfer_pkg::OP_CPYBA);
    chk({auxOut, accOut}, 8'h99);
    // suppressed copy, with the skip event raising the interrupt
    // every event kind has fired by now, index 6 included
    wb(1'b0, skip_xfer_pkg::ADR_STAT, 32'h0);
    chk(rd, 32'hf);
    wb(1'b1, skip_xfer_pkg::ADR_MASK, 32'h1);
    wb(1'b0, skip_xfer_pkg::ADR_MASK, 32'h0);
    chk(rd, 32'h1);
    setab(4'h9, 4'h2);
    intCtrlOne <= 4'h0;
    raise(0);
    step(skip_xfer_pkg::OP_SKT1);
    step(skip_xfer_pkg::OP_CPYBA);
    chk(accOut, 4'h2);
    chk(irq, 1'b1);
    wb(1'b0, skip_xfer_pkg::ADR_STAT, 32'h0);
    chk(rd, 32'h3);
    chk(irq, 1'b0);
    step(skip_xfer_pkg::OP_CPYBA);
    chk(accOut, 4'h9);
    wb(1'b0, 4'h6, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, skip_xfer_pkg::ADR_CTRL, 32'h1);
    chk(instrBusy, 1'b1);
    wb(1'b1, skip_xfer_pkg::ADR_CTRL, 32'h0);
    chk(instrBusy, 1'b0);
    finishTest();
  end
endmodule // test_skip_xfer_exec
`default_nettype wire
